// *** verilog/sbsc_pkg.sv ***
// constants, types and helpers of the sensorless start-up and commutation host
// assumes a 50 MHz pclk and a driver that returns three emulated position bits
// Functional notes
// - the filter switch clock stays between 250 kHz and 4 MHz.
// - software should pick about 390 times the log mean of motor and chop rates.
// - high and low side gates of the active phases share one chop signal.
// - chop duty stays between 15 and 95 percent of the chop period.
// - one commutation table serves both directions, fixed by start-up.
// - start-up is forced stepping, accelerating to a handover speed.
// - start-up current is set by its own duty, start speed and acceleration.
// - the same chop scheme runs in start-up and in feedback.
// - the first in-order position change after ramp hands over to feedback.
// - a sequence error restarts forced mode, from rest or on the fly.
// - the host makes the filter clock, 1.25 MHz giving about 3 kHz.
package sbsc_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int FCLK_MIN_HZ = 250_000;
  localparam int FCLK_MAX_HZ = 4_000_000;
  localparam int FCLK_DEF_HZ = 1_250_000;
  localparam int DIV_MIN = (CLK_HZ + 2 * FCLK_MAX_HZ - 1) / (2 * FCLK_MAX_HZ);
  localparam int DIV_MAX = CLK_HZ / (2 * FCLK_MIN_HZ);
  localparam int DIV_DEF = CLK_HZ / (2 * FCLK_DEF_HZ);
  localparam int CHOP_DEF_HZ = 20_000;
  localparam int PER_DEF = CLK_HZ / CHOP_DEF_HZ;
  localparam int DUTY_MIN_PCT = 15;
  localparam int DUTY_MAX_PCT = 95;
  localparam int RUN_DUTY_DEF = PER_DEF / 2;
  localparam int START_DUTY_DEF = PER_DEF / 4;
  localparam int STEP_START_US = 10_000;
  localparam int STEP_HAND_US = 1_000;
  localparam int START_CYC = STEP_START_US * (CLK_HZ / 1_000_000);
  localparam int HAND_CYC = STEP_HAND_US * (CLK_HZ / 1_000_000);
  localparam int ACCEL_DEF = 500;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FDIV = 8'h04;
  localparam logic [7:0] OFF_PER = 8'h08;
  localparam logic [7:0] OFF_DUTY = 8'h0C;
  localparam logic [7:0] OFF_START = 8'h10;
  localparam logic [7:0] OFF_ACCEL = 8'h14;
  localparam logic [7:0] OFF_HAND = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_IST = 8'h20;
  localparam logic [7:0] OFF_IMASK = 8'h24;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DIR = 1;
  localparam int CTRL_FLY = 2;
  localparam int IRQ_HAND = 0;
  localparam int IRQ_SEQ = 1;
  localparam int NIRQ = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_RAMP, ST_WAIT, ST_RUN} sbsc_state_t;
  // position pattern to step, 3'h7 marks an illegal pattern
  function automatic logic [2:0] sbsc_hall_step(input logic [2:0] h);
    case (h)
      3'h1: sbsc_hall_step = 3'h0;
      3'h3: sbsc_hall_step = 3'h1;
      3'h2: sbsc_hall_step = 3'h2;
      3'h6: sbsc_hall_step = 3'h3;
      3'h4: sbsc_hall_step = 3'h4;
      3'h5: sbsc_hall_step = 3'h5;
      default: sbsc_hall_step = 3'h7;
    endcase
  endfunction
  // step to {high side w,v,u, low side w,v,u}
  function automatic logic [5:0] sbsc_drive(input logic [2:0] s);
    case (s)
      3'h0: sbsc_drive = 6'h0A;
      3'h1: sbsc_drive = 6'h0C;
      3'h2: sbsc_drive = 6'h14;
      3'h3: sbsc_drive = 6'h11;
      3'h4: sbsc_drive = 6'h21;
      3'h5: sbsc_drive = 6'h22;
      default: sbsc_drive = 6'h00;
    endcase
  endfunction
endpackage

// *** verilog/sbsc_ctrl.sv ***
// host controller: filter clock, common chop, forced start-up, feedback steps
// assumes an APB master on pclk and driver position bits from another domain
module sbsc_ctrl
  import sbsc_pkg::*;
#(
  parameter int P_START_CYC = START_CYC,
  parameter int P_HAND_CYC = HAND_CYC,
  parameter int P_CW = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] emulated_position_outputs,
  output logic filter_switch_clock,
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo,
  output logic irq
);
  if (P_HAND_CYC < 1 || P_HAND_CYC >= P_START_CYC || P_START_CYC >= 2 ** P_CW) begin : g_chk
    $error("sbsc_ctrl: step periods do not fit");
  end

  logic [2:0] ctrl_q;
  logic [7:0] fdiv_q;
  logic [15:0] per_q;
  logic [31:0] duty_q;
  logic [P_CW-1:0] start_q;
  logic [15:0] accel_q;
  logic [P_CW-1:0] hand_q;
  logic [NIRQ-1:0] ist_q;
  logic [NIRQ-1:0] imask_q;
  logic [NIRQ-1:0] ev;
  logic [31:0] prdata_q;
  logic err_q;
  logic [31:0] rdata;
  logic hit;
  logic wr;
  sbsc_state_t st_q;
  logic dir_q;
  logic [2:0] step_q;
  logic [P_CW-1:0] tmr_q;
  logic [P_CW-1:0] sper_q;
  logic [7:0] fcnt_q;
  logic fclk_q;
  logic [15:0] pcnt_q;
  logic chop_q;
  logic [15:0] duty_eff;
  logic [15:0] dmin;
  logic [15:0] dmax;
  logic [15:0] draw;
  logic [31:0] pmin;
  logic [31:0] pmax;
  logic [2:0] hs1_q;
  logic [2:0] hs2_q;
  logic [2:0] hs3_q;
  logic [2:0] hall_q;
  logic [2:0] hall_prev_q;
  logic hall_chg;
  logic [2:0] hstep;
  logic [2:0] hstep_prev;
  logic in_order;
  logic [5:0] drv;
  logic [2:0] gh_q;
  logic [2:0] gl_q;
  logic irq_q;

  // next step in the latched direction, wrapping over six
  function automatic logic [2:0] nxt(input logic [2:0] s, input logic d);
    if (d) begin
      nxt = (s == 3'h0) ? 3'h5 : s - 3'h1;
    end else begin
      nxt = (s == 3'h5) ? 3'h0 : s + 3'h1;
    end
  endfunction

  // read mux, sampled in the setup cycle so prdata comes from a flop
  always_comb begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      OFF_CTRL: rdata = {29'h0, ctrl_q};
      OFF_FDIV: rdata = {24'h0, fdiv_q};
      OFF_PER: rdata = {16'h0, per_q};
      OFF_DUTY: rdata = duty_q;
      OFF_START: rdata = 32'(start_q);
      OFF_ACCEL: rdata = {16'h0, accel_q};
      OFF_HAND: rdata = 32'(hand_q);
      OFF_STAT: rdata = {22'h0, hall_q, step_q, dir_q, chop_q, 2'(st_q)};
      OFF_IST: rdata = 32'(ist_q);
      OFF_IMASK: rdata = 32'(imask_q);
      default: hit = 1'b0;
    endcase
  end

  // apb answer: one access cycle, error for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q <= rdata;
      err_q <= !hit;
    end
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;
  assign wr = psel & penable & pwrite & !err_q;

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 3'h0;
      fdiv_q <= 8'(DIV_DEF);
      per_q <= 16'(PER_DEF);
      duty_q <= {16'(START_DUTY_DEF), 16'(RUN_DUTY_DEF)};
      start_q <= P_CW'(P_START_CYC);
      accel_q <= 16'(ACCEL_DEF);
      hand_q <= P_CW'(P_HAND_CYC);
      imask_q <= '0;
    end else if (wr) begin
      case (paddr)
        OFF_CTRL: ctrl_q <= pwdata[2:0];
        OFF_FDIV: begin
          if (pwdata < 32'(DIV_MIN)) begin
            fdiv_q <= 8'(DIV_MIN);
          end else if (pwdata > 32'(DIV_MAX)) begin
            fdiv_q <= 8'(DIV_MAX);
          end else begin
            fdiv_q <= pwdata[7:0];
          end
        end
        OFF_PER: per_q <= pwdata[15:0];
        OFF_DUTY: duty_q <= pwdata;
        OFF_START: start_q <= pwdata[P_CW-1:0];
        OFF_ACCEL: accel_q <= pwdata[15:0];
        OFF_HAND: hand_q <= pwdata[P_CW-1:0];
        OFF_IMASK: imask_q <= pwdata[NIRQ-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, a new event beats a same-cycle write of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= '0;
      irq_q <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~((wr && paddr == OFF_IST) ? pwdata[NIRQ-1:0] : '0)) | ev;
      irq_q <= |(ist_q & imask_q);
    end
  end
  assign irq = irq_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt_q <= 8'h00;
      fclk_q <= 1'b0;
    end else if (fcnt_q >= fdiv_q - 8'h01) begin
      fcnt_q <= 8'h00;
      fclk_q <= !fclk_q;
    end else begin
      fcnt_q <= fcnt_q + 8'h01;
    end
  end
  assign filter_switch_clock = fclk_q;

  always_comb begin
    pmin = 32'(per_q) * 32'(DUTY_MIN_PCT);
    pmax = 32'(per_q) * 32'(DUTY_MAX_PCT);
    dmin = 16'(pmin / 32'h64);
    dmax = 16'(pmax / 32'h64);
    draw = (st_q == ST_RUN) ? duty_q[15:0] : duty_q[31:16];
    if (draw < dmin) begin
      duty_eff = dmin;
    end else if (draw > dmax) begin
      duty_eff = dmax;
    end else begin
      duty_eff = draw;
    end
  end

  // one chop signal in every mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_q <= 16'h0000;
      chop_q <= 1'b0;
    end else begin
      pcnt_q <= (pcnt_q + 16'h0001 >= per_q) ? 16'h0000 : pcnt_q + 16'h0001;
      chop_q <= pcnt_q < duty_eff;
    end
  end

  // high and low side share chop
  assign drv = sbsc_drive(step_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gh_q <= 3'h0;
      gl_q <= 3'h0;
    end else if (st_q == ST_IDLE || !chop_q) begin
      gh_q <= 3'h0;
      gl_q <= 3'h0;
    end else begin
      gh_q <= drv[5:3];
      gl_q <= drv[2:0];
    end
  end
  assign gate_hi = gh_q;
  assign gate_lo = gl_q;

  // three-stage sync, a change counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs1_q <= 3'h0;
      hs2_q <= 3'h0;
      hs3_q <= 3'h0;
      hall_q <= 3'h0;
      hall_prev_q <= 3'h0;
    end else begin
      hs1_q <= emulated_position_outputs;
      hs2_q <= hs1_q;
      hs3_q <= hs2_q;
      if (hs2_q == hs3_q) begin
        hall_q <= hs3_q;
      end
      hall_prev_q <= hall_q;
    end
  end
  assign hall_chg = hall_q != hall_prev_q;
  assign hstep = sbsc_hall_step(hall_q);
  assign hstep_prev = sbsc_hall_step(hall_prev_q);
  assign in_order = hstep != 3'h7 && hstep_prev != 3'h7 && hstep == nxt(hstep_prev, dir_q);

  // sequencer; a stop request wins over everything else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      dir_q <= 1'b0;
      step_q <= 3'h0;
      tmr_q <= '0;
      sper_q <= '0;
      ev <= '0;
    end else begin
      ev <= '0;
      if (!ctrl_q[CTRL_EN]) begin
        st_q <= ST_IDLE;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            st_q <= ST_RAMP;
            dir_q <= ctrl_q[CTRL_DIR];
            step_q <= 3'h0;
            sper_q <= start_q;
            tmr_q <= start_q;
          end
          ST_RAMP, ST_WAIT: begin
            if (st_q == ST_WAIT && hall_chg && in_order) begin
              st_q <= ST_RUN;
              step_q <= hstep;
              ev[IRQ_HAND] <= 1'b1;
            end else if (tmr_q == '0) begin
              step_q <= nxt(step_q, dir_q);
              tmr_q <= sper_q;
              if (sper_q > hand_q + P_CW'(accel_q)) begin
                sper_q <= sper_q - P_CW'(accel_q);
              end else begin
                sper_q <= hand_q;
                st_q <= ST_WAIT;
              end
            end else begin
              tmr_q <= tmr_q - P_CW'(1);
            end
          end
          ST_RUN: begin
            if (hall_chg) begin
              if (in_order) begin
                step_q <= hstep;
              end else begin
                ev[IRQ_SEQ] <= 1'b1;
                st_q <= ST_RAMP;
                sper_q <= ctrl_q[CTRL_FLY] ? hand_q : start_q;
                tmr_q <= ctrl_q[CTRL_FLY] ? hand_q : start_q;
              end
            end
          end
        endcase
      end
    end
  end

  property p_div_range;
    @(posedge pclk) disable iff (!presetn)
    fdiv_q >= 8'(DIV_MIN) && fdiv_q <= 8'(DIV_MAX);
  endproperty
  a_div_range: assert property (p_div_range) else $error("filter divider out of range");

  property p_fclk_toggle;
    @(posedge pclk) disable iff (!presetn)
    $changed(fclk_q) |-> $past(fcnt_q) >= $past(fdiv_q) - 8'h01;
  endproperty
  a_fclk_toggle: assert property (p_fclk_toggle) else $error("filter clock edge early");

  property p_chop_common;
    @(posedge pclk) disable iff (!presetn)
    (|{gh_q, gl_q}) |-> $past(chop_q) && gh_q != 3'h0 && gl_q != 3'h0;
  endproperty
  a_chop_common: assert property (p_chop_common) else $error("gates chopped apart");

  property p_duty_clamp;
    @(posedge pclk) disable iff (!presetn)
    duty_eff >= dmin && duty_eff <= dmax;
  endproperty
  a_duty_clamp: assert property (p_duty_clamp) else $error("duty outside limits");

  property p_one_table;
    @(posedge pclk) disable iff (!presetn)
    (|gh_q) |-> {gh_q, gl_q} == sbsc_drive($past(step_q));
  endproperty
  a_one_table: assert property (p_one_table) else $error("gates differ from table");

  property p_start_forced;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_IDLE && ctrl_q[CTRL_EN] |=> st_q == ST_RAMP && step_q == 3'h0;
  endproperty
  a_start_forced: assert property (p_start_forced) else $error("start not forced");

  property p_ramp_down;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_RAMP && ctrl_q[CTRL_EN] ##1 st_q != ST_IDLE |-> sper_q <= $past(sper_q);
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("step period grew in ramp");

  property p_handover;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_WAIT && ctrl_q[CTRL_EN] && hall_chg && in_order
      |=> st_q == ST_RUN ##1 ist_q[IRQ_HAND];
  endproperty
  a_handover: assert property (p_handover) else $error("handover missed");

  property p_seq_err;
    @(posedge pclk) disable iff (!presetn)
    st_q == ST_RUN && ctrl_q[CTRL_EN] && hall_chg && !in_order
      |=> st_q == ST_RAMP ##1 ist_q[IRQ_SEQ] [*2];
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("sequence error not handled");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    |(ist_q & imask_q) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

// *** tb/sbsc_drv_model.sv ***
// behavioural driver: emulated position bits from a rotor that follows the gates
// assumes the host makes the filter clock; the rotor moves once per filter clock
module sbsc_drv_model (
  input wire logic filter_switch_clock,
  input wire logic [2:0] gate_hi,
  input wire logic [2:0] gate_lo,
  input wire logic valid_i,
  input wire logic dir_i,
  input wire logic glitch_i,
  output logic [2:0] emulated_position_outputs
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] PAT [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  logic [2:0] rotor_q = 3'h0;
  logic [2:0] last_q = 3'h0;
  logic glitch_q = 1'b0;
  // energised pair to step, 7 while chopped off
  function automatic logic [2:0] pair_step(input logic [5:0] g);
    case (g)
      6'h0A: pair_step = 3'h0;
      6'h0C: pair_step = 3'h1;
      6'h14: pair_step = 3'h2;
      6'h11: pair_step = 3'h3;
      6'h21: pair_step = 3'h4;
      6'h22: pair_step = 3'h5;
      default: pair_step = 3'h7;
    endcase
  endfunction
  // keep the last pair through chop off-time, else the rotor would stall
  always @(gate_hi, gate_lo) begin
    if (pair_step({gate_hi, gate_lo}) != 3'h7) last_q = pair_step({gate_hi, gate_lo});
  end
  always @(posedge filter_switch_clock) begin
    glitch_q <= glitch_i;
    if (glitch_i && !glitch_q) rotor_q <= (rotor_q >= 3'h3) ? rotor_q - 3'h3 : rotor_q + 3'h3;
    else if (dir_i) rotor_q <= (last_q == 3'h0) ? 3'h5 : last_q - 3'h1;
    else rotor_q <= (last_q == 3'h5) ? 3'h0 : last_q + 3'h1;
  end
  assign emulated_position_outputs = valid_i ? PAT[rotor_q] : 3'h0; // 000 while too slow
endmodule

// *** tb/tb_top.sv ***
// self-checking bench for the sensorless start-up and commutation host
// assumes the driver model beside it; APB driven here, expectations noted in a queue
module tb_top import sbsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] RA [10] = '{OFF_CTRL, OFF_FDIV, OFF_PER, OFF_DUTY, OFF_START,
    OFF_ACCEL, OFF_HAND, OFF_STAT, OFF_IST, OFF_IMASK};
  localparam logic [31:0] RV [10] = '{32'h0, 32'h14, 32'h9C4, 32'h0271_04E2, 32'hC8,
    32'h1F4, 32'h28, 32'h0, 32'h0, 32'h0};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, fsc, irq;
  logic [2:0] pos, ghi, glo;
  logic valid = 1'b0, dir = 1'b0, glitch = 1'b0;
  logic [31:0] rng = 32'h6;
  logic [64:0] exq [$];
  int n_mismatch = 0, compares = 0;
  sbsc_ctrl #(.P_START_CYC(200), .P_HAND_CYC(40)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .emulated_position_outputs(pos),
    .filter_switch_clock(fsc), .gate_hi(ghi), .gate_lo(glo), .irq(irq));
  sbsc_drv_model drv (.filter_switch_clock(fsc), .gate_hi(ghi), .gate_lo(glo),
    .valid_i(valid), .dir_i(dir), .glitch_i(glitch), .emulated_position_outputs(pos));
  initial begin
    forever #10 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer, expectation noted first; master holds until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] e, input logic er);
    exq.push_back({m, e, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, m, e, 1'b0);
  endtask
  // compare each completed access with the oldest note
  always @(posedge pclk) begin
    logic [64:0] n;
    if (psel && penable && pready) begin
      n = exq.pop_front();
      chk(prdata & n[64:33], n[32:1]);
      chk({31'h0, pslverr}, {31'h0, n[0]});
    end
  end
  task automatic wait_irq(input logic v);
    int k;
    k = 0;
    do begin @(negedge pclk); k++; end while (irq !== v && k < 5000);
    chk({31'h0, irq}, {31'h0, v});
    @(posedge pclk);
  endtask
  // high time of the filter clock, counted on settled samples
  task automatic meas_half(input int exp);
    int n;
    n = 0;
    @(posedge fsc);
    @(negedge pclk);
    while (fsc === 1'b1) begin n++; @(negedge pclk); end
    chk(n, exp);
    @(posedge pclk);
  endtask
  // gate on-time over one chop period of 100, and hi/lo agreement
  task automatic meas_duty(input int exp);
    int on, bad;
    on = 0;
    bad = 0;
    repeat (100) begin
      @(negedge pclk);
      if (ghi !== 3'h0) on++;
      if ((ghi !== 3'h0) !== (glo !== 3'h0)) bad++;
    end
    chk(on, exp);
    chk(bad, 0);
    @(posedge pclk);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    int k;
    logic [31:0] v;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 10; i++) rd(RA[i], RV[i], (i == 7) ? 32'h3FB : 32'hFFFF_FFFF);
    wr(OFF_STAT, 32'hFFFF);
    rd(OFF_STAT, 32'h0, 32'h3FB);
    apb(1'b1, 8'h28, 32'h5, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h28, 32'h0, 32'h0, 32'h0, 1'b1);
    $display("test registers done");
    meas_half(20);
    wr(OFF_FDIV, 32'h3);
    rd(OFF_FDIV, 32'h7, 32'hFFFF_FFFF);
    wr(OFF_FDIV, 32'hC8);
    rd(OFF_FDIV, 32'h64, 32'hFFFF_FFFF);
    wr(OFF_FDIV, 32'hA);
    meas_half(10);
    for (int i = 0; i < 3; i++) begin
      rng = xs(rng);
      v = {20'h0, rng[11:0]} + 32'h40;
      wr(OFF_PER, v);
      rd(OFF_PER, v, 32'hFFFF_FFFF);
    end
    $display("test filter clock and period done");
    wr(OFF_PER, 32'h64);
    wr(OFF_DUTY, 32'h0005_EA60);
    wr(OFF_ACCEL, 32'h14);
    wr(OFF_IMASK, 32'h1);
    valid <= 1'b1;
    for (int d = 0; d < 2; d++) begin
      dir <= d[0];
      wr(OFF_CTRL, d[0] ? 32'h7 : 32'h1);
      k = 0;
      do begin @(negedge pclk); k++; end while (ghi === 3'h0 && k < 500);
      chk({26'h0, ghi, glo}, 32'h0A);
      @(posedge pclk);
      meas_duty(15);
      wait_irq(1'b1);
      rd(OFF_IST, 32'h1, 32'h3);
      rd(OFF_STAT, {28'h0, d[0], 3'b011}, 32'hB);
      meas_duty(95);
      wr(OFF_IST, 32'h1);
      wait_irq(1'b0);
      wr(OFF_IMASK, 32'h2);
      glitch <= 1'b1;
      wait_irq(1'b1);
      rd(OFF_STAT, 32'h1, 32'h3);
      rd(OFF_IST, 32'h2, 32'h3);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_IMASK, 32'h0);
      wait_irq(1'b0);
      rd(OFF_IST, 32'h2, 32'h2);
      wr(OFF_IST, 32'h3);
      rd(OFF_IST, 32'h0, 32'h3);
      chk({26'h0, ghi, glo}, 32'h0);
      rd(OFF_STAT, 32'h0, 32'h3);
      wr(OFF_IMASK, 32'h1);
      glitch <= 1'b0;
      $display("test start-up and feedback pass %0d done", d);
    end
    give_verdict();
  end
endmodule
